// ==== bench/thermal_overload_supervisor_tb_top.sv ====
// Self-checking testbench of the thermal overload supervisor
`timescale 1ns/1ps
module thermal_overload_supervisor_tb_top;
    localparam int SEC = 20;
    logic        clk_in = 1'b0, rstn_in = 1'b0, start_cmd_in = 1'b0, sensor_active_in = 1'b0;
    logic        direct_start_in = 1'b0, supply_ok_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic        motor_on_out, trip_out, irq_out;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, rdata_out, v, rec;
    logic [11:0] load = 12'h000, c1, c2, c3;
    int          error_cnt = 0, compares = 0, r;

    always #25 clk_in = ~clk_in;
    tos_supervisor #(.SEC_CYCLES(SEC)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .cur_l1_in(c1), .cur_l2_in(c2), .cur_l3_in(c3), .rated_cur_in(12'h064),
        .start_cmd_in(start_cmd_in), .sensor_active_in(sensor_active_in),
        .direct_start_in(direct_start_in), .supply_ok_in(supply_ok_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .motor_on_out(motor_on_out), .trip_out(trip_out), .irq_out(irq_out));
    tos_motor_model i_motor (.clk_in(clk_in), .motor_on_in(motor_on_out), .load_in(load),
        .cur_l1_out(c1), .cur_l2_out(c2), .cur_l3_out(c3));

    // ****************
    // Tasks
    // ****************
    task automatic results();
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 chk(rdata_out, e);
    endtask
    // Waits on the trip flag or on the motor; running out ends the run
    task automatic wait_for(input bit on_trip, input logic lvl, input int lim);
        int n;
        n = 0;
        while (((on_trip ? trip_out : motor_on_out) !== lvl) && n < lim) begin
            @(posedge clk_in);
            #1 n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("[ERR] %0t ns: wait ran out", $time);
            results();
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    initial begin
        r = $urandom(32'hE2E2);
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        rdchk(tos_pkg::REG_CTRL, {9'h000, tos_pkg::CTRL_RESET});
        rdchk(tos_pkg::REG_RECOV, {5'h00, tos_pkg::REC_DEF_S});
        rdchk(tos_pkg::REG_WARN, 16'h0000);
        rdchk(tos_pkg::REG_IDLE, 16'h0000);
        rdchk(tos_pkg::REG_RESET_TH, {4'h0, tos_pkg::RESET_TH_DEF});
        rdchk(tos_pkg::REG_STATUS, 16'h0000);
        rdchk(4'hF, 16'h0000);
        wr(tos_pkg::REG_IRQ_MASK, 16'h0080);
        wr(tos_pkg::REG_CTRL, 16'h0010);
        rdchk(tos_pkg::REG_CTRL, 16'h0004);
        chk({15'h0000, irq_out}, 16'h0001);
        wr(tos_pkg::REG_IRQ_ST, 16'h0080);
        #1 chk({15'h0000, irq_out}, 16'h0000);
        sensor_active_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        wr(tos_pkg::REG_CTRL, 16'h0010);
        rdchk(tos_pkg::REG_STATUS, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(tos_pkg::REG_CTRL, 16'(k + 4));
            rdchk(tos_pkg::REG_CTRL, (k < 3) ? 16'(k + 4) : 16'h0006);
        end
        direct_start_in <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(tos_pkg::REG_CTRL, 16'(k << 2));
            rdchk(tos_pkg::REG_CTRL, (k < 2) ? 16'(k << 2) : 16'h0004);
        end
        direct_start_in <= 1'b0;
        wr(tos_pkg::REG_CTRL, 16'h000C);
        rdchk(tos_pkg::REG_CTRL, 16'h000C);
        rec = 16'h005A;
        for (int k = 0; k < 14; k++) begin
            v = (k == 0) ? 16'h0708 : (k == 1) ? 16'h001E : (k == 2) ? 16'h003C :
                16'(30 * $urandom_range(0, 64)) + 16'($urandom_range(0, 3) == 0);
            wr(tos_pkg::REG_RECOV, v);
            if (v >= 60 && v <= 1800 && v % 30 == 0) rec = v;
            rdchk(tos_pkg::REG_RECOV, rec);
        end
        // Latched trip: reset is refused while cooling, honoured after
        wr(tos_pkg::REG_RECOV, 16'h003C);
        wr(tos_pkg::REG_CTRL, 16'h0004);
        load <= 12'h320;
        start_cmd_in <= 1'b1;
        wait_for(1'b1, 1'b1, 20000);
        start_cmd_in <= 1'b0;
        wr(tos_pkg::REG_CTRL, 16'h0044);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, trip_out}, 16'h0001);
        repeat (70 * SEC) @(posedge clk_in);
        #1 chk({15'h0000, trip_out}, 16'h0001);
        wr(tos_pkg::REG_CTRL, 16'h0044);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, trip_out}, 16'h0000);
        // Automatic restart with the start command held
        wr(tos_pkg::REG_CTRL, 16'h0005);
        start_cmd_in <= 1'b1;
        wait_for(1'b1, 1'b1, 20000);
        load <= 12'h064;
        wait_for(1'b0, 1'b1, 70 * SEC);
        chk({14'h0000, trip_out, motor_on_out}, 16'h0001);
        // Warning only still trips past the self-protection limit
        wr(tos_pkg::REG_CTRL, 16'h0006);
        load <= 12'hFFF;
        wait_for(1'b1, 1'b1, 20000);
        chk({15'h0000, trip_out}, 16'h0001);
        results();
    end
endmodule

bind tos_supervisor tos_supervisor_monitor #(.SEC_CYCLES(SEC_CYCLES)) i_mon (
    .clk_in(clk_in), .rstn_in(rstn_in), .start_cmd_in(start_cmd_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .motor_on_out(motor_on_out), .trip_out(trip_out), .irq_out(irq_out));

// ==== bench/tos_motor_model.sv ====
// Phase current source standing in for the motor and its measurement
`timescale 1ns/1ps
module tos_motor_model (
    input  wire logic        clk_in,
    input  wire logic        motor_on_in,
    input  wire logic [11:0] load_in,
    output logic      [11:0] cur_l1_out,
    output logic      [11:0] cur_l2_out,
    output logic      [11:0] cur_l3_out
);
    // A stopped motor draws nothing; phase L2 runs one count above L1 and L3 one below
    always_ff @(posedge clk_in) begin
        cur_l1_out <= motor_on_in ? load_in : 12'h000;
        cur_l2_out <= motor_on_in ? load_in + 12'h001 : 12'h000;
        cur_l3_out <= motor_on_in ? load_in - 12'h001 : 12'h000;
    end
endmodule

// ==== bench/tos_supervisor_monitor.sv ====
// Port-level checker of the thermal overload supervisor
`timescale 1ns/1ps
module tos_supervisor_monitor #(
    parameter int SEC_CYCLES = 20
) (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        start_cmd_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        motor_on_out,
    input wire logic        trip_out,
    input wire logic        irq_out
);
    // One tick of slack: the first second tick may land right after the trip
    localparam int TRIP_MIN = 59 * SEC_CYCLES;
    int         trip_cnt_ff;
    int         nxt_trip_cnt;
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;

    // ****************
    // Helper state
    // ****************
    always_comb begin
        nxt_trip_cnt = trip_out ? trip_cnt_ff + 1 : 0;
        nxt_mask     = (wr_in && addr_in == tos_pkg::REG_IRQ_MASK) ? wdata_in[7:0] : mask_ff;
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trip_cnt_ff <= 0;
            mask_ff     <= 8'h00;
        end else begin
            trip_cnt_ff <= nxt_trip_cnt;
            mask_ff     <= nxt_mask;
        end
    end

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_RD_IDLE_ZERO:
        assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("stray read data");
    AST_UNMAPPED_ZERO:
        assert property (rd_in && addr_in > tos_pkg::REG_RESET_TH |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    AST_HEAT_WIDTH:
        assert property (rd_in && addr_in == tos_pkg::REG_HEAT |=> rdata_out[15:12] == 4'h0)
        else $error("heating value too wide");
    AST_STATUS_TRIP:
        assert property (rd_in && addr_in == tos_pkg::REG_STATUS
            |=> rdata_out[tos_pkg::ST_TRIP] == $past(trip_out)) else $error("trip flag wrong");
    AST_TRIP_MOTOR_OFF:
        assert property (trip_out ##1 trip_out |-> !motor_on_out) else $error("motor on in trip");
    AST_START_NEEDED:
        assert property (!start_cmd_in [*4] |-> !motor_on_out) else $error("motor on unasked");
    AST_TRIP_MIN_TIME:
        assert property ($fell(trip_out) |-> trip_cnt_ff >= TRIP_MIN) else $error("trip too short");
    AST_IRQ_MASKED:
        assert property (mask_ff == 8'h00 |-> !irq_out) else $error("masked interrupt seen");
endmodule

// ==== design/tos_sec_tick.sv ====
// Once-per-second enable pulse generator
`timescale 1ns/1ps
module tos_sec_tick #(
    parameter int CYCLES = tos_pkg::SEC_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    output logic      tick_out
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        tick_ff;
    logic        nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + 32'h1;
        if (cnt_ff >= 32'(CYCLES - 1)) begin
            nxt_cnt  = 32'h0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;
endmodule

// ==== design/tos_supervisor.sv ====
// Thermal overload supervisor: heating model, trip logic, timers, registers
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Heating from phase currents, rated current, class
// [RULE2] Responses: latched trip, auto restart, warn only
// [RULE3] Latched trip needs cool-down then reset command
// [RULE4] Auto restart after recovery if start held
// [RULE5] Above 178 percent always trip
// [RULE6] Class sets cold trip time at 7.2x
// [RULE7] Classes 5, 10, 15, 20, off; default 10
// [RULE8] Class off refused without winding sensor
// [RULE9] Direct startup refuses classes 15 and 20
// [RULE10] Trip reset ignored while recovery runs
// [RULE11] Recovery 60 to 1800 s, 30 s steps
// [RULE12] Supply loss during recovery extends it
// [RULE13] Heating prewarning above 0..95 percent limit
// [RULE14] Remaining-time prewarning below 0..500 s limit
// [RULE15] Idle timer after operational switch-off
// [RULE16] Idle expiry: above half to half, else zero
// [RULE17] Status flags for model, trip, timers, warnings
// [RULE18] Heating fixed point, 100 percent is trip
// [RULE19] All second timers from one tick
module tos_supervisor #(
    parameter int SEC_CYCLES = tos_pkg::SEC_CYCLES,
    parameter int CUR_W      = 12
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [CUR_W-1:0] cur_l1_in,
    input  wire logic [CUR_W-1:0] cur_l2_in,
    input  wire logic [CUR_W-1:0] cur_l3_in,
    input  wire logic [CUR_W-1:0] rated_cur_in,
    input  wire logic             start_cmd_in,
    input  wire logic             sensor_active_in,
    input  wire logic             direct_start_in,
    input  wire logic             supply_ok_in,
    input  wire logic [3:0]       addr_in,
    input  wire logic [15:0]      wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [15:0]      rdata_out,
    output logic                  motor_on_out,
    output logic                  trip_out,
    output logic                  irq_out
);
    // ****************
    // Pin synchronisers
    // ****************
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {supply_ok_in, start_cmd_in, sensor_active_in};
            sync2_ff <= sync1_ff;
        end
    end
    logic sensor_on;
    logic start_cmd;
    logic supply_ok;
    assign sensor_on = sync2_ff[0];
    assign start_cmd = sync2_ff[1];
    assign supply_ok = sync2_ff[2];

    logic sec_tick;
    tos_sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_out (sec_tick)
    );

    // ****************
    // Configuration registers
    // ****************
    localparam int NUM_EV_W = tos_pkg::NUM_EV;
    logic [6:0]  ctrl_ff;
    logic [6:0]  nxt_ctrl;
    logic [10:0] recov_s_ff;
    logic [10:0] nxt_recov_s;
    logic [4:0]  pw_pct_ff;
    logic [4:0]  nxt_pw_pct;
    logic [8:0]  pw_time_ff;
    logic [8:0]  nxt_pw_time;
    logic [7:0]  idle_s_ff;
    logic [7:0]  nxt_idle_s;
    logic [11:0] reset_th_ff;
    logic [11:0] nxt_reset_th;
    logic [NUM_EV_W-1:0] irq_st_ff;
    logic [NUM_EV_W-1:0] nxt_irq_st;
    logic [NUM_EV_W-1:0] irq_mask_ff;
    logic [NUM_EV_W-1:0] nxt_irq_mask;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        treset_req;
    logic        reject_ev;
    logic [NUM_EV_W-1:0] status;
    logic [NUM_EV_W-1:0] status_q_ff;
    logic [11:0] heat_ff;

    function automatic logic class_ok(input logic [2:0] c, input logic sens,
                                      input logic direct);
        class_ok = (c <= 3'(tos_pkg::TOS_CLASS_OFF));
        if (c == 3'(tos_pkg::TOS_CLASS_OFF) && !sens)
            class_ok = 1'b0;                                      // [RULE8]
        if (direct && (c == 3'(tos_pkg::TOS_CLASS_15) || c == 3'(tos_pkg::TOS_CLASS_20)))
            class_ok = 1'b0;                                      // [RULE9]
    endfunction

    always_comb begin
        nxt_ctrl     = ctrl_ff;
        nxt_recov_s  = recov_s_ff;
        nxt_pw_pct   = pw_pct_ff;
        nxt_pw_time  = pw_time_ff;
        nxt_idle_s   = idle_s_ff;
        nxt_reset_th = reset_th_ff;
        nxt_irq_mask = irq_mask_ff;
        treset_req   = 1'b0;
        reject_ev    = 1'b0;
        nxt_rdata    = 16'h0;
        // Events set, write-one clears; the set wins in the same cycle
        nxt_irq_st = irq_st_ff;
        if (wr_in && addr_in == tos_pkg::REG_IRQ_ST)
            nxt_irq_st = irq_st_ff & ~wdata_in[NUM_EV_W-1:0];
        if (wr_in) begin
            unique case (addr_in)
                tos_pkg::REG_CTRL: begin
                    treset_req = wdata_in[tos_pkg::CTRL_TRESET_BIT];
                    if (wdata_in[1:0] <= 2'(tos_pkg::TOS_RESP_WARN))
                        nxt_ctrl[1:0] = wdata_in[1:0];                    // [RULE2]
                    else
                        reject_ev = 1'b1;
                    if (class_ok(wdata_in[4:2], sensor_on, direct_start_in))
                        nxt_ctrl[4:2] = wdata_in[4:2];                    // [RULE7]
                    else
                        reject_ev = 1'b1;
                    nxt_ctrl[tos_pkg::CTRL_VFP_BIT] = wdata_in[tos_pkg::CTRL_VFP_BIT];
                end
                tos_pkg::REG_RECOV: begin
                    if (wdata_in >= 16'(tos_pkg::REC_MIN_S) && wdata_in <= 16'(tos_pkg::REC_MAX_S)
                        && (wdata_in % 16'(tos_pkg::REC_STEP_S)) == 16'h0)
                        nxt_recov_s = wdata_in[10:0];                     // [RULE11]
                    else
                        reject_ev = 1'b1;
                end
                tos_pkg::REG_WARN: begin
                    // Heating limit in 5 % steps (low bits), time in s (high)
                    if (wdata_in[4:0] <= tos_pkg::PCT_MAX_STEPS)
                        nxt_pw_pct = wdata_in[4:0];                       // [RULE13]
                    else
                        reject_ev = 1'b1;
                    if ({2'h0, wdata_in[13:5]} <= 11'(tos_pkg::RT_MAX_S))
                        nxt_pw_time = wdata_in[13:5];                     // [RULE14]
                end
                tos_pkg::REG_IDLE:     nxt_idle_s   = wdata_in[7:0];        // [RULE15]
                tos_pkg::REG_IRQ_MASK: nxt_irq_mask = wdata_in[NUM_EV_W-1:0];
                tos_pkg::REG_RESET_TH: nxt_reset_th = wdata_in[11:0];       // [RULE18]
                default: ;
            endcase
        end
        nxt_irq_st = nxt_irq_st | (status & ~status_q_ff);
        if (reject_ev)
            nxt_irq_st[tos_pkg::ST_REJECT] = 1'b1;
        if (rd_in) begin
            unique case (addr_in)
                tos_pkg::REG_CTRL:     nxt_rdata = {10'h0, ctrl_ff[5:0]};
                tos_pkg::REG_RECOV:    nxt_rdata = {5'h0, recov_s_ff};
                tos_pkg::REG_WARN:     nxt_rdata = {2'h0, pw_time_ff, pw_pct_ff};
                tos_pkg::REG_IDLE:     nxt_rdata = {8'h0, idle_s_ff};
                tos_pkg::REG_STATUS:   nxt_rdata = {8'h0, status};         // [RULE17]
                tos_pkg::REG_HEAT:     nxt_rdata = {4'h0, heat_ff};
                tos_pkg::REG_IRQ_ST:   nxt_rdata = {8'h0, irq_st_ff};
                tos_pkg::REG_IRQ_MASK: nxt_rdata = {8'h0, irq_mask_ff};
                tos_pkg::REG_RESET_TH: nxt_rdata = {4'h0, reset_th_ff};
                default:               nxt_rdata = 16'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff     <= tos_pkg::CTRL_RESET;
            recov_s_ff  <= tos_pkg::REC_DEF_S;
            pw_pct_ff   <= 5'h00;
            pw_time_ff  <= 9'h000;
            idle_s_ff   <= 8'h00;
            reset_th_ff <= tos_pkg::RESET_TH_DEF;
            irq_st_ff   <= '0;
            irq_mask_ff <= '0;
            rdata_ff    <= 16'h0;
            status_q_ff <= '0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            recov_s_ff  <= nxt_recov_s;
            pw_pct_ff   <= nxt_pw_pct;
            pw_time_ff  <= nxt_pw_time;
            idle_s_ff   <= nxt_idle_s;
            reset_th_ff <= nxt_reset_th;
            irq_st_ff   <= nxt_irq_st;
            irq_mask_ff <= nxt_irq_mask;
            rdata_ff    <= nxt_rdata;
            status_q_ff <= status;
        end
    end

    // ****************
    // Thermal model
    // ****************
    // Heating rises by (I/Ie)^2 and falls by 1/64 of its value each
    // second. The rise gain per class makes a cold motor at 7.2 x Ie reach
    // 100 % in roughly the class time; this is a coarse model only.
    logic [2:0]  cls;
    logic        model_off;
    logic [CUR_W-1:0] imax;
    logic [15:0] ratio;     // I/Ie in 1/64 units
    logic [63:0] rise;
    logic [11:0] nxt_heat;
    logic [5:0]  class_s;
    assign cls       = ctrl_ff[4:2];
    assign model_off = (cls == 3'(tos_pkg::TOS_CLASS_OFF));

    always_comb begin
        imax = cur_l1_in;
        if (cur_l2_in > imax) imax = cur_l2_in;
        if (cur_l3_in > imax) imax = cur_l3_in;
        unique case (cls)                                             // [RULE6]
            3'(tos_pkg::TOS_CLASS_5):  class_s = 6'h05;
            3'(tos_pkg::TOS_CLASS_15): class_s = 6'h0F;
            3'(tos_pkg::TOS_CLASS_20): class_s = 6'h14;
            default:                   class_s = 6'h0A;
        endcase
        ratio = (rated_cur_in == '0) ? 16'h0 :
                16'((32'(imax) << 6) / 32'(rated_cur_in));              // [RULE1]
        // At ratio 7.2 (461/64) rise = 1024/class_s per second
        rise = (64'(ratio) * 64'(ratio) * 64'(tos_pkg::HEAT_FULL) * 64'h64)
               / (64'(class_s) * 64'(tos_pkg::TRIP_MULT_X10) * 64'(tos_pkg::TRIP_MULT_X10)
                  * 64'h1000);
    end

    // ****************
    // Trip control
    // ****************
    tos_pkg::tos_state_type state_ff;
    tos_pkg::tos_state_type nxt_state;
    logic [10:0] rec_cnt_ff;
    logic [10:0] nxt_rec_cnt;
    logic [7:0]  idle_cnt_ff;
    logic [7:0]  nxt_idle_cnt;
    logic        motor_ff;
    logic        nxt_motor;
    logic        over;
    logic        self_trip;
    logic        cooling;
    logic        idle_run;
    logic        pw_heat;
    logic        pw_time;
    logic [11:0] rem;
    logic [11:0] heat_plus;

    assign over      = !model_off && heat_ff >= tos_pkg::HEAT_FULL;
    assign self_trip = heat_ff > tos_pkg::HEAT_SELF;                  // [RULE5]
    assign cooling   = (rec_cnt_ff != 11'h0);
    assign idle_run  = (idle_cnt_ff != 8'h0);

    always_comb begin
        // Decay term: heating leaves about 1/64 per second when idle
        heat_plus = (rise > 64'(tos_pkg::HEAT_MAX)) ? tos_pkg::HEAT_MAX : rise[11:0];
        nxt_heat  = heat_ff;
        if (model_off)
            nxt_heat = 12'h0;
        else if (sec_tick) begin                                      // [RULE19]
            nxt_heat = heat_ff - (heat_ff >> 6);
            nxt_heat = (nxt_heat > tos_pkg::HEAT_MAX - heat_plus) ? tos_pkg::HEAT_MAX :
                       nxt_heat + heat_plus;
        end
        nxt_state    = state_ff;
        nxt_rec_cnt  = rec_cnt_ff;
        nxt_idle_cnt = idle_cnt_ff;
        nxt_motor    = motor_ff;
        // Supply loss stalls the countdown, prolonging recovery
        if (sec_tick && cooling && !(ctrl_ff[tos_pkg::CTRL_VFP_BIT] && !supply_ok))
            nxt_rec_cnt = rec_cnt_ff - 11'h1;                         // [RULE12]
        unique case (state_ff)
            tos_pkg::TOS_RUN: begin
                nxt_motor = start_cmd;
                if (self_trip || (over && ctrl_ff[1:0] != 2'(tos_pkg::TOS_RESP_WARN))) begin
                    nxt_state   = tos_pkg::TOS_TRIP;                  // [RULE2] [RULE5]
                    nxt_motor   = 1'b0;
                    nxt_rec_cnt = recov_s_ff;
                    nxt_idle_cnt = 8'h0;
                end else if (motor_ff && !start_cmd) begin
                    nxt_idle_cnt = idle_s_ff;                         // [RULE15]
                end else if (start_cmd) begin
                    nxt_idle_cnt = 8'h0;
                end else if (sec_tick && idle_run) begin
                    nxt_idle_cnt = idle_cnt_ff - 8'h1;
                    if (idle_cnt_ff == 8'h1)
                        nxt_heat = (heat_ff > tos_pkg::HEAT_HALF) ?
                                   tos_pkg::HEAT_HALF : 12'h0;        // [RULE16]
                end
            end
            tos_pkg::TOS_TRIP: begin
                nxt_motor = 1'b0;
                if (!cooling && !self_trip) begin
                    if (ctrl_ff[1:0] == 2'(tos_pkg::TOS_RESP_AUTO)) begin
                        if (start_cmd)
                            nxt_state = tos_pkg::TOS_RUN;             // [RULE4]
                    end else if (heat_ff < reset_th_ff && treset_req)
                        nxt_state = tos_pkg::TOS_RUN;                 // [RULE3] [RULE10]
                end
            end
            default: begin
                nxt_state = tos_pkg::TOS_TRIP;
                nxt_motor = 1'b0;
            end
        endcase
        // Remaining time to trip: (100 % - heat) / rise seconds
        if (heat_plus == 12'h0 || heat_ff >= tos_pkg::HEAT_FULL)
            rem = (heat_ff >= tos_pkg::HEAT_FULL) ? 12'h0 : tos_pkg::HEAT_MAX;
        else
            rem = (tos_pkg::HEAT_FULL - heat_ff) / heat_plus;
        pw_time = (pw_time_ff != 9'h0) && !model_off && motor_ff
                  && rem < {3'h0, pw_time_ff};                        // [RULE14]
        pw_heat = (pw_pct_ff != 5'h0) && !model_off &&
                  32'(heat_ff) * 32'h64 > 32'(pw_pct_ff) * 32'h5 * 32'(tos_pkg::HEAT_FULL);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            heat_ff     <= 12'h0;
            state_ff    <= tos_pkg::TOS_RUN;
            rec_cnt_ff  <= 11'h0;
            idle_cnt_ff <= 8'h0;
            motor_ff    <= 1'b0;
        end else begin
            heat_ff     <= nxt_heat;
            state_ff    <= nxt_state;
            rec_cnt_ff  <= nxt_rec_cnt;
            idle_cnt_ff <= nxt_idle_cnt;
            motor_ff    <= nxt_motor;
        end
    end

    always_comb begin
        status = '0;
        status[tos_pkg::ST_OFF]     = model_off;                      // [RULE17]
        status[tos_pkg::ST_OVL]     = over;
        status[tos_pkg::ST_TRIP]    = (state_ff == tos_pkg::TOS_TRIP);
        status[tos_pkg::ST_IDLE]    = idle_run;
        status[tos_pkg::ST_COOL]    = cooling;
        status[tos_pkg::ST_PW_HEAT] = pw_heat;                        // [RULE13]
        status[tos_pkg::ST_PW_TIME] = pw_time;
        status[tos_pkg::ST_REJECT]  = 1'b0;
    end

    assign rdata_out    = rdata_ff;
    assign motor_on_out = motor_ff;
    assign trip_out     = (state_ff == tos_pkg::TOS_TRIP);
    assign irq_out      = |(irq_st_ff & irq_mask_ff);
endmodule

// ==== pkg/tos_pkg.sv ====
// Package of constants and types for the thermal overload supervisor
package tos_pkg;
    // ****************
    // Heating value format: unsigned fixed point, 100 % equals 1024
    // ****************
    localparam int HEAT_W               = 12;
    localparam logic [11:0] HEAT_FULL   = 12'h400;
    localparam logic [11:0] HEAT_HALF   = 12'h200;
    localparam logic [11:0] HEAT_SELF   = 12'h71F;  // 178 % of 1024, rounded up
    localparam logic [11:0] HEAT_MAX    = 12'hFFF;
    // Cold trip multiple 7.2 expressed in tenths
    localparam int TRIP_MULT_X10        = 72;

    // ****************
    // Timing
    // ****************
    localparam int CLK_HZ               = 20000000;
    localparam int SEC_CYCLES           = CLK_HZ;
    localparam int REC_MIN_S            = 60;
    localparam int REC_MAX_S            = 1800;
    localparam int REC_STEP_S           = 30;
    localparam logic [10:0] REC_DEF_S   = 11'h05A;
    localparam logic [8:0] RT_MAX_S     = 9'h1F4;
    localparam logic [4:0] PCT_MAX_STEPS = 5'h13;   // 19 steps of 5 % = 95 %

    // ****************
    // Register bus
    // ****************
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_RECOV    = 4'h1;
    localparam logic [3:0] REG_WARN     = 4'h2;
    localparam logic [3:0] REG_IDLE     = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_HEAT     = 4'h5;
    localparam logic [3:0] REG_IRQ_ST   = 4'h6;
    localparam logic [3:0] REG_IRQ_MASK = 4'h7;
    localparam logic [3:0] REG_RESET_TH = 4'h8;
    // CTRL fields
    localparam int CTRL_RESP_LSB        = 0;   // 2 bits
    localparam int CTRL_CLASS_LSB       = 2;   // 3 bits
    localparam int CTRL_VFP_BIT         = 5;
    localparam int CTRL_TRESET_BIT      = 6;   // write one: trip reset
    localparam logic [6:0] CTRL_RESET   = 7'h04;   // latched trip, class 10
    localparam logic [11:0] RESET_TH_DEF = 12'h300; // 75 %
    // Status / event bit positions
    localparam int ST_OFF               = 0;
    localparam int ST_OVL               = 1;
    localparam int ST_TRIP              = 2;
    localparam int ST_IDLE              = 3;
    localparam int ST_COOL              = 4;
    localparam int ST_PW_HEAT           = 5;
    localparam int ST_PW_TIME           = 6;
    localparam int ST_REJECT            = 7;
    localparam int NUM_EV               = 8;

    typedef enum logic [1:0] {
        TOS_RESP_LATCH = 2'h0,
        TOS_RESP_AUTO  = 2'h1,
        TOS_RESP_WARN  = 2'h2
    } tos_resp_type;

    typedef enum logic [2:0] {
        TOS_CLASS_5   = 3'h0,
        TOS_CLASS_10  = 3'h1,
        TOS_CLASS_15  = 3'h2,
        TOS_CLASS_20  = 3'h3,
        TOS_CLASS_OFF = 3'h4
    } tos_class_type;

    typedef enum logic [1:0] {
        TOS_RUN  = 2'h0,
        TOS_TRIP = 2'h1,
        TOS_COOL = 2'h3
    } tos_state_type;
endpackage
